// ---- core/ldc_pkg.sv ----
// constants and carrier types for the led driver config and interrupt block
package ldc_pkg;
    // register indices on the internal register port
    localparam logic [7:0] ADDR_CFG   = 8'h06;
    localparam logic [7:0] ADDR_MASK  = 8'h07;
    localparam logic [7:0] ADDR_FRAME = 8'h08;
    localparam logic [7:0] ADDR_STAT  = 8'h0e;

    // values after reset
    localparam logic [7:0] RST_CFG   = 8'h00;
    localparam logic [7:0] RST_MASK  = 8'h20;
    localparam logic [7:0] RST_FRAME = 8'h3f;
    localparam logic [7:0] RST_STAT  = 8'h20;
    localparam logic [7:0] CLR_STAT  = 8'h00;
    localparam logic [7:0] RD_NONE   = 8'h00;

    // status and mask bit positions
    localparam int IB_FRAME  = 7;
    localparam int IB_WDOG   = 6;
    localparam int IB_POR    = 5;
    localparam int IB_OTEMP  = 4;
    localparam int IB_LOWVDD = 3;
    localparam int IB_OPEN   = 2;
    localparam int IB_SHORT  = 1;
    localparam int IB_MOVIE  = 0;

    // field widths and codes
    localparam int FRAME_W   = 6;
    localparam int SYNC_LEN  = 3;
    localparam logic [2:0] MEM_INVALID = 3'h0;
    localparam logic [2:0] MEM_LAST    = 3'h6;
    localparam logic [6:0] BCAST_ADDR  = 7'h3f;

    // global configuration, laid out as the register
    typedef struct packed {
        logic       autoclr;
        logic       route;
        logic       open_dis;
        logic       dot_corr;
        logic       bcast_en;
        logic [2:0] mem_layout;
    } ldc_cfg_t;

    // interrupt causes, laid out as the status register
    typedef struct packed {
        logic frame;
        logic wdog;
        logic por;
        logic otemp;
        logic lowvdd;
        logic open;
        logic short_err;
        logic movie;
    } ldc_evt_t;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ldc_req_t;

    // sequencer progress
    typedef struct packed {
        logic               frame_done;
        logic [FRAME_W-1:0] frame_num;
        logic               last_loop;
        logic               show_end;
    } ldc_seq_t;
endpackage

// ---- core/ldc_flag.sv ----
// sticky flag with set priority over clear
`timescale 1ns/1ps
module ldc_flag #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // control
    input  wire logic set,
    input  wire logic clr,
    // state
    output logic      q
);
    logic q_r;
    logic q_nxt;

    // a set in the clearing cycle wins so no event is lost
    assign q_nxt = set ? 1'b1 : (clr ? 1'b0 : q_r);

    // flag storage
    always_ff @(posedge core_clk) begin
        if (srst) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule // ldc_flag

// ---- core/ldc_cfg_irq.sv ----
// global configuration, interrupt mask, frame interrupt and status flags
`timescale 1ns/1ps
module ldc_cfg_irq #(
    parameter int FRAME_W = ldc_pkg::FRAME_W
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              srst,
    // register port from the serial interface
    input  wire ldc_pkg::ldc_req_t req,
    output logic [7:0]             rd_data_r,
    output logic                   rd_valid_r,
    // address recognition
    input  wire logic [6:0]        own_addr,
    input  wire logic [6:0]        rx_addr,
    input  wire logic              rx_addr_vld,
    output logic                   addr_hit_r,
    // analog monitors, asynchronous levels
    input  wire logic              low_vdd_pin,
    input  wire logic              overtemp_pin,
    // events from same-clock logic, one-cycle pulses
    input  wire logic              por_evt,
    input  wire logic              wdog_evt,
    input  wire logic              open_err_evt,
    input  wire logic              short_err_evt,
    input  wire logic              movie_fin_evt,
    input  wire logic              data_wr_evt,
    input  wire ldc_pkg::ldc_seq_t seq,
    // configuration to the rest of the driver
    output ldc_pkg::ldc_cfg_t      cfg_r,
    output logic                   mem_valid_r,
    output logic                   cfg_locked_r,
    output logic                   led_disable_r,
    output logic                   low_vdd_flag_r,
    // interrupt pin level, active high
    output logic                   irq_r
);
    // register state
    ldc_pkg::ldc_cfg_t  cfg_nxt;
    logic [7:0]         mask_r;
    logic [7:0]         mask_nxt;
    logic [FRAME_W-1:0] frame_sel_r;
    logic [FRAME_W-1:0] frame_sel_nxt;
    logic               locked_nxt;

    // synchronisers for the analog monitors
    logic [ldc_pkg::SYNC_LEN-1:0] vdd_sync_r;
    logic [ldc_pkg::SYNC_LEN-1:0] temp_sync_r;
    logic                         vdd_lvl_r;
    logic                         temp_lvl_r;
    logic                         vdd_lvl_nxt;
    logic                         temp_lvl_nxt;
    logic                         vdd_rise;
    logic                         temp_rise;

    // decode
    logic wr_cfg;
    logic wr_mask;
    logic wr_frame;
    logic rd_stat;
    logic [7:0] rd_mux;

    // status
    ldc_pkg::ldc_evt_t evt;
    ldc_pkg::ldc_evt_t stat;
    logic              frame_hit;
    logic              lowvdd_q;
    logic              vdd_clr;
    logic              irq_nxt;
    logic              hit_nxt;
    logic              led_dis_nxt;

    // register port decode
    assign wr_cfg   = req.wr && (req.addr == ldc_pkg::ADDR_CFG);
    assign wr_mask  = req.wr && (req.addr == ldc_pkg::ADDR_MASK);
    assign wr_frame = req.wr && (req.addr == ldc_pkg::ADDR_FRAME);
    assign rd_stat  = req.rd && (req.addr == ldc_pkg::ADDR_STAT);

    // locked fields keep their value, the rest take the write
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_cfg) begin
            cfg_nxt.autoclr  = req.wdata[7];
            cfg_nxt.route    = req.wdata[6];
            cfg_nxt.open_dis = req.wdata[5];
            cfg_nxt.bcast_en = req.wdata[3];
            if (!cfg_locked_r) begin
                cfg_nxt.dot_corr   = req.wdata[4];
                cfg_nxt.mem_layout = req.wdata[2:0];
            end
        end
    end

    // the lock only clears with a device reset
    assign locked_nxt = cfg_locked_r | data_wr_evt;

    // mask and frame select writes; frame bits 7:6 are not stored
    assign mask_nxt      = wr_mask ? req.wdata : mask_r;
    assign frame_sel_nxt = wr_frame ? req.wdata[FRAME_W-1:0] : frame_sel_r;

    // global configuration register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_r <= ldc_pkg::ldc_cfg_t'(ldc_pkg::RST_CFG);
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // interrupt mask; the power-on cause is enabled out of reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mask_r <= ldc_pkg::RST_MASK;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // frame select for the frame interrupt
    always_ff @(posedge core_clk) begin
        if (srst) begin
            frame_sel_r <= ldc_pkg::RST_FRAME[FRAME_W-1:0];
        end else begin
            frame_sel_r <= frame_sel_nxt;
        end
    end

    // data-section lock; no register write can free it, only srst
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_locked_r <= 1'b0;
        end else begin
            cfg_locked_r <= locked_nxt;
        end
    end

    // code 000 and 111 select no layout
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_valid_r <= 1'b0;
        end else begin
            mem_valid_r <= (cfg_nxt.mem_layout != ldc_pkg::MEM_INVALID) &&
                           (cfg_nxt.mem_layout <= ldc_pkg::MEM_LAST);
        end
    end

    // supply monitor synchroniser; the first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (srst) begin
            vdd_sync_r <= '0;
        end else begin
            vdd_sync_r <= {vdd_sync_r[1:0], low_vdd_pin};
        end
    end

    // temperature monitor synchroniser, same three stages
    always_ff @(posedge core_clk) begin
        if (srst) begin
            temp_sync_r <= '0;
        end else begin
            temp_sync_r <= {temp_sync_r[1:0], overtemp_pin};
        end
    end

    // a level change counts only once stages two and three agree
    assign vdd_lvl_nxt  = (vdd_sync_r[1] == vdd_sync_r[2]) ? vdd_sync_r[2] : vdd_lvl_r;
    assign temp_lvl_nxt = (temp_sync_r[1] == temp_sync_r[2]) ? temp_sync_r[2] : temp_lvl_r;

    // filtered supply level; idle low so reset gives no false edge
    always_ff @(posedge core_clk) begin
        if (srst) begin
            vdd_lvl_r <= 1'b0;
        end else begin
            vdd_lvl_r <= vdd_lvl_nxt;
        end
    end

    // filtered temperature level
    always_ff @(posedge core_clk) begin
        if (srst) begin
            temp_lvl_r <= 1'b0;
        end else begin
            temp_lvl_r <= temp_lvl_nxt;
        end
    end

    // a new detection is one event, a level held high raises nothing more
    assign vdd_rise  = vdd_lvl_nxt && !vdd_lvl_r;
    assign temp_rise = temp_lvl_nxt && !temp_lvl_r;

    // frame interrupt waits for the last loop, not the first pass
    assign frame_hit = seq.frame_done && seq.last_loop &&
                       (seq.frame_num == frame_sel_r);

    // event bundle in status bit order
    assign evt.frame     = frame_hit;
    assign evt.wdog      = wdog_evt;
    assign evt.por       = por_evt;
    assign evt.otemp     = temp_rise;
    assign evt.lowvdd    = vdd_rise;
    assign evt.open      = open_err_evt;
    assign evt.short_err = short_err_evt;
    assign evt.movie     = movie_fin_evt;

    // one sticky bit per cause, emptied by a status read
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_stat
            ldc_flag #(
                .RST_VAL (ldc_pkg::RST_STAT[gi])
            ) u_stat (
                .core_clk (core_clk),
                .srst     (srst),
                .set      (evt[gi]),
                .clr      (rd_stat),
                .q        (stat[gi])
            );
        end
    endgenerate

    // supply-low flag ends with a movie or picture when autoclear is on
    assign vdd_clr = seq.show_end && cfg_r.autoclr;

    ldc_flag #(
        .RST_VAL (1'b0)
    ) u_lowvdd (
        .core_clk (core_clk),
        .srst     (srst),
        .set      (vdd_rise),
        .clr      (vdd_clr),
        .q        (lowvdd_q)
    );

    // pin: direct supply flag when routed, else masked status
    always_comb begin
        if (cfg_r.route) begin
            irq_nxt = lowvdd_q;
        end else begin
            irq_nxt = |(stat & mask_r);
        end
    end

    // register read data; unmapped addresses read zero
    always_comb begin
        case (req.addr)
            ldc_pkg::ADDR_CFG:   rd_mux = cfg_r;
            ldc_pkg::ADDR_MASK:  rd_mux = mask_r;
            ldc_pkg::ADDR_FRAME: rd_mux = {{(8-FRAME_W){1'b0}}, frame_sel_r};
            ldc_pkg::ADDR_STAT:  rd_mux = stat;
            default:             rd_mux = ldc_pkg::RD_NONE;
        endcase
    end

    // own address always answers, shared address only when enabled
    assign hit_nxt = rx_addr_vld && ((rx_addr == own_addr) ||
                     (cfg_r.bcast_en && (rx_addr == ldc_pkg::BCAST_ADDR)));

    // open-test failures turn into disable requests when enabled
    assign led_dis_nxt = open_err_evt && cfg_r.open_dis;

    // read data holds until the next read so a slow host still sees it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_data_r <= ldc_pkg::RD_NONE;
        end else begin
            rd_data_r <= req.rd ? rd_mux : rd_data_r;
        end
    end

    // read valid, one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= req.rd;
        end
    end

    // address match pulse
    always_ff @(posedge core_clk) begin
        if (srst) begin
            addr_hit_r <= 1'b0;
        end else begin
            addr_hit_r <= hit_nxt;
        end
    end

    // led disable request pulse
    always_ff @(posedge core_clk) begin
        if (srst) begin
            led_disable_r <= 1'b0;
        end else begin
            led_disable_r <= led_dis_nxt;
        end
    end

    // supply-low flag copy, one cycle behind the internal flag
    always_ff @(posedge core_clk) begin
        if (srst) begin
            low_vdd_flag_r <= 1'b0;
        end else begin
            low_vdd_flag_r <= lowvdd_q;
        end
    end

    // interrupt level, registered so the pin never glitches
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end
endmodule // ldc_cfg_irq

// ---- test/ldc_cfg_irq_assertions.sv ----
// concurrent checks on the config and interrupt block ports
`timescale 1ns/1ps
module ldc_cfg_irq_chk #(
    parameter int FRAME_W = ldc_pkg::FRAME_W
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              srst,
    // register port and address match
    input wire ldc_pkg::ldc_req_t req,
    input wire logic              rd_valid_r,
    input wire logic [6:0]        own_addr,
    input wire logic [6:0]        rx_addr,
    input wire logic              rx_addr_vld,
    input wire logic              addr_hit_r,
    // events
    input wire logic              open_err_evt,
    input wire logic              data_wr_evt,
    // watched outputs
    input wire ldc_pkg::ldc_cfg_t cfg_r,
    input wire logic              cfg_locked_r,
    input wire logic              led_disable_r,
    input wire logic              low_vdd_flag_r,
    input wire logic              irq_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // register port and address recognition
    property p_rd_valid; req.rd |=> rd_valid_r; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
    property p_bc_hit; rx_addr_vld && cfg_r.bcast_en && rx_addr == ldc_pkg::BCAST_ADDR |=> addr_hit_r; endproperty
    a_bc_hit: assert property (p_bc_hit) else $error("shared address not taken");
    property p_bc_off;
        rx_addr_vld && !cfg_r.bcast_en && rx_addr == ldc_pkg::BCAST_ADDR && rx_addr != own_addr |=> !addr_hit_r;
    endproperty
    a_bc_off: assert property (p_bc_off) else $error("shared address taken while off");
    // lock is sticky and shields layout and dot correction
    property p_lock_set; data_wr_evt |=> cfg_locked_r [*3]; endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    property p_lock_hold;
        cfg_locked_r && req.wr && req.addr == ldc_pkg::ADDR_CFG |=> $stable({cfg_r.dot_corr, cfg_r.mem_layout});
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked field changed");
    // open handling, power-on cause and supply routing
    property p_open_dis; open_err_evt && cfg_r.open_dis |=> led_disable_r; endproperty
    a_open_dis: assert property (p_open_dis) else $error("open led not disabled");
    property p_por_irq; $fell(srst) |-> ##[1:2] irq_r; endproperty
    a_por_irq: assert property (p_por_irq) else $error("power-on interrupt missing");
    property p_route; cfg_r.route && $rose(low_vdd_flag_r) |-> ##[0:2] irq_r; endproperty
    a_route: assert property (p_route) else $error("pin not following supply flag");

    c_stat_rd: cover property (req.rd && req.addr == ldc_pkg::ADDR_STAT && irq_r);
    c_locked_wr: cover property (cfg_locked_r && req.wr);
    c_route: cover property (cfg_r.route && irq_r);
endmodule // ldc_cfg_irq_chk

bind ldc_cfg_irq ldc_cfg_irq_chk #(.FRAME_W(FRAME_W)) chk_u (.core_clk, .srst, .req, .rd_valid_r, .own_addr,
    .rx_addr, .rx_addr_vld, .addr_hit_r, .open_err_evt, .data_wr_evt, .cfg_r, .cfg_locked_r, .led_disable_r,
    .low_vdd_flag_r, .irq_r);

// ---- test/ldc_host_model.sv ----
// host model driving the register port with single-byte strobes
`timescale 1ns/1ps
module ldc_host_model (
    // clock
    input wire logic         core_clk,
    // register port
    output ldc_pkg::ldc_req_t req,
    input wire logic [7:0]   rd_data_r,
    input wire logic         rd_valid_r
);
    initial req = '{1'b0, 1'b0, 8'h00, 8'h00};

    // one-cycle strobe; idle address and data flip so stale values never pass
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        req = '{1'b1, 1'b0, a, d};
        @(negedge core_clk);
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask

    // data is taken in the cycle where valid stands, else unknown
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        req = '{1'b0, 1'b0, ~a, 8'hff};
        d = rd_valid_r ? rd_data_r : 8'hxx;
    endtask
endmodule // ldc_host_model

// ---- test/ldc_cfg_irq_tb_top.sv ----
// self-checking bench for the config and interrupt block
`timescale 1ns/1ps
module ldc_cfg_irq_tb_top;
    logic              core_clk = 1'b0;
    logic              srst = 1'b1;
    ldc_pkg::ldc_req_t req;
    ldc_pkg::ldc_seq_t seq = '0;
    ldc_pkg::ldc_cfg_t cfg_r;
    logic [7:0]        rd_data_r;
    logic [7:0]        ev = 8'h00;   // cause pulses by status bit
    logic [6:0]        rx_addr = 7'h00;
    logic              rx_addr_vld = 1'b0, low_vdd_pin = 1'b0, overtemp_pin = 1'b0, data_wr_evt = 1'b0;
    logic              rd_valid_r, addr_hit_r, mem_valid_r, cfg_locked_r, led_disable_r, low_vdd_flag_r, irq_r;
    int                err_count = 0, checked = 0;

    always #2 core_clk = ~core_clk;

    ldc_host_model host_u (.core_clk, .req, .rd_data_r, .rd_valid_r);
    ldc_cfg_irq dut_u (.core_clk, .srst, .req, .rd_data_r, .rd_valid_r, .own_addr(7'h30), .rx_addr, .rx_addr_vld,
        .addr_hit_r, .low_vdd_pin, .overtemp_pin, .por_evt(ev[5]), .wdog_evt(ev[6]), .open_err_evt(ev[2]),
        .short_err_evt(ev[1]), .movie_fin_evt(ev[0]), .data_wr_evt, .seq, .cfg_r, .mem_valid_r, .cfg_locked_r,
        .led_disable_r, .low_vdd_flag_r, .irq_r);

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp, string name);
        logic [7:0] d;
        host_u.rd(a, d);
        chk(name, d, exp);
    endtask
    // pins stay high afterwards so the filter sees a level
    task automatic fire(int k);
        @(negedge core_clk);
        case (k)
            7: seq = '{1'b1, 6'h3f, 1'b1, 1'b0};
            4: overtemp_pin = 1'b1;
            3: low_vdd_pin = 1'b1;
            default: ev[k] = 1'b1;
        endcase
        cyc(1);
        seq = '0;
        ev = 8'h00;
    endtask
    task automatic show_end();
        seq.show_end = 1'b1;
        cyc(1);
        seq.show_end = 1'b0;
        cyc(3);
    endtask

    task automatic t_reset();
        rdc(ldc_pkg::ADDR_CFG, 8'h00, "cfg_rst");
        rdc(ldc_pkg::ADDR_MASK, 8'h20, "mask_rst");
        rdc(ldc_pkg::ADDR_FRAME, 8'h3f, "frame_rst");
        chk("mem_valid_rst", {7'h00, mem_valid_r}, 8'h00);
        chk("irq_por", {7'h00, irq_r}, 8'h01);
        rdc(ldc_pkg::ADDR_STAT, 8'h20, "stat_rst");
        cyc(2);
        chk("irq_release", {7'h00, irq_r}, 8'h00);
        rdc(8'h0f, 8'h00, "unmapped");
    endtask
    // each mask bit alone lets its own cause reach the pin
    task automatic t_mask();
        for (int i = 0; i < 8; i++) begin
            host_u.wr(ldc_pkg::ADDR_MASK, 8'h01 << i);
            fire(i);
            cyc(8);
            chk("irq_cause", {7'h00, irq_r}, 8'h01);
            low_vdd_pin = 1'b0;
            overtemp_pin = 1'b0;
            rdc(ldc_pkg::ADDR_STAT, 8'h01 << i, "stat_cause");
            cyc(2);
            chk("irq_clear", {7'h00, irq_r}, 8'h00);
        end
    endtask
    // frame not on its last loop is ignored; masked causes stay off the pin
    task automatic t_off();
        host_u.wr(ldc_pkg::ADDR_MASK, 8'h80);
        seq = '{1'b1, 6'h3f, 1'b0, 1'b0};
        cyc(1);
        seq = '0;
        cyc(6);
        chk("frame_early", {7'h00, irq_r}, 8'h00);
        host_u.wr(ldc_pkg::ADDR_MASK, 8'h00);
        for (int i = 0; i < 8; i++) fire(i);
        cyc(8);
        chk("irq_masked", {7'h00, irq_r}, 8'h00);
        low_vdd_pin = 1'b0;
        overtemp_pin = 1'b0;
        rdc(ldc_pkg::ADDR_STAT, 8'hff, "stat_all");
    endtask
    task automatic t_route();
        host_u.wr(ldc_pkg::ADDR_CFG, 8'hc0);
        show_end();
        chk("flag_autoclr", {7'h00, low_vdd_flag_r}, 8'h00);
        chk("pin_low", {7'h00, irq_r}, 8'h00);
        host_u.wr(ldc_pkg::ADDR_CFG, 8'h40);
        low_vdd_pin = 1'b1;
        cyc(8);
        chk("pin_follow", {7'h00, irq_r}, 8'h01);
        low_vdd_pin = 1'b0;
        show_end();
        chk("flag_kept", {7'h00, low_vdd_flag_r}, 8'h01);
        rdc(ldc_pkg::ADDR_STAT, 8'h08, "stat_route");
    endtask
    task automatic t_open_addr(logic on);
        host_u.wr(ldc_pkg::ADDR_CFG, on ? 8'h28 : 8'h00);
        ev[2] = 1'b1;
        rx_addr = ldc_pkg::BCAST_ADDR;
        rx_addr_vld = 1'b1;
        cyc(1);
        ev[2] = 1'b0;
        rx_addr_vld = 1'b0;
        chk("led_disable", {7'h00, led_disable_r}, {7'h00, on});
        chk("bcast_hit", {7'h00, addr_hit_r}, {7'h00, on});
        rdc(ldc_pkg::ADDR_STAT, 8'h04, "stat_open");
    endtask
    // after the first data write only a reset frees layout and dot correction
    task automatic t_lock();
        host_u.wr(ldc_pkg::ADDR_CFG, 8'h01);
        chk("mem_first", {7'h00, mem_valid_r}, 8'h01);
        host_u.wr(ldc_pkg::ADDR_CFG, 8'h07);
        chk("mem_111", {7'h00, mem_valid_r}, 8'h00);
        host_u.wr(ldc_pkg::ADDR_CFG, 8'h1e);
        rdc(ldc_pkg::ADDR_CFG, 8'h1e, "cfg_wr");
        chk("mem_valid", {7'h00, mem_valid_r}, 8'h01);
        data_wr_evt = 1'b1;
        cyc(1);
        data_wr_evt = 1'b0;
        chk("locked", {7'h00, cfg_locked_r}, 8'h01);
        host_u.wr(ldc_pkg::ADDR_CFG, 8'h01);
        rdc(ldc_pkg::ADDR_CFG, 8'h16, "cfg_locked");
        chk("cfg_port", cfg_r, 8'h16);
        host_u.wr(ldc_pkg::ADDR_FRAME, 8'hc5);
        rdc(ldc_pkg::ADDR_FRAME, 8'h05, "frame_wr");
        // only the selected frame number raises the frame cause
        seq = '{1'b1, 6'h3f, 1'b1, 1'b0};
        cyc(1);
        seq = '0;
        rdc(ldc_pkg::ADDR_STAT, 8'h00, "frame_other");
        seq = '{1'b1, 6'h05, 1'b1, 1'b0};
        cyc(1);
        seq = '0;
        rdc(ldc_pkg::ADDR_STAT, 8'h80, "frame_sel_hit");
    endtask
    // a device reset in mid-run restores defaults and frees the lock
    task automatic t_unlock();
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        t_reset();
        chk("unlocked", {7'h00, cfg_locked_r}, 8'h00);
        host_u.wr(ldc_pkg::ADDR_CFG, 8'h15);
        rdc(ldc_pkg::ADDR_CFG, 8'h15, "cfg_unlocked");
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // whole run is about 270 cycles
    initial begin
        #20000;
        err_count++;
        final_report();
    end
    initial begin
        cyc(16);
        srst = 1'b0;
        t_reset();
        t_mask();
        t_off();
        t_route();
        t_open_addr(1'b1);
        t_open_addr(1'b0);
        t_lock();
        t_unlock();
        final_report();
    end
endmodule // ldc_cfg_irq_tb_top
